//--- hdl/i2c_iface_map.svh
`ifndef I2C_IFACE_MAP_SVH
`define I2C_IFACE_MAP_SVH
// Operation
// [RULE1] starts slave; master after start, slave after stop/loss
// [RULE2] bytes of eight bits, most significant first
// [RULE3] first byte(s) after start carry address
// [RULE4] ninth pulse carries acknowledge from receiver
// [RULE5] master clocks, software requests start and stop
// [RULE6] own 7/10-bit address, switchable general call
// [RULE7] acknowledge drive switchable by software
// [RULE8] standard 100 kHz or fast 400 kHz
// [RULE9] clock held low until software services byte
// [RULE10] clock from divider, base set by mode
// [RULE11] disabled: pins follow general purpose port
// [RULE12] software programs frequency range before use
// [RULE13] after start, compare address byte with own
// [RULE14] ten-bit header 11110xx0 plus two high bits
// [RULE15] ten-bit header match acknowledged if enabled
// [RULE16] mismatch: ignore until next start
// [RULE17] match: ack, flags, hold until status one read
// [RULE18] seven-bit direction bit read from data register
// [RULE19] ten-bit: receive; transmit after restart header 11110xx1
// [RULE20] receive byte: ack, flags, hold until reads
// [RULE21] transmit: hold until data written; flags on ack
// [RULE22] stop after slave transfer sets stop flags
// [RULE23] status one read clears address event
// [RULE24] status one then data read clears byte event
// [RULE25] status two read clears stop event
// [RULE26] lines only pulled low, else released

`define ADR_CTRL 8'h00
`define ADR_SR1 8'h04
`define ADR_SR2 8'h08
`define ADR_DIV 8'h0c
`define ADR_OWN_LO 8'h10
`define ADR_OWN_HI 8'h14
`define ADR_DATA 8'h18

`define CR_PE 5
`define CR_ENGC 4
`define CR_START 3
`define CR_ACK 2
`define CR_STOP 1
`define CR_ITE 0

`define SR1_EVF 7
`define SR1_TEN 6
`define SR1_TRA 5
`define SR1_BUSY 4
`define SR1_BTF 3
`define SR1_ADDRESSED_AS_SLAVE_FLAG 2
`define SR1_MSL 1
`define SR1_SB 0

`define SR2_AF 4
`define SR2_STOP_DETECTED_FLAG 3
`define SR2_ARLO 2
`define SR2_GCAL 0

`define DIV_FM 7
`define OWN_HI_TEN 0
`define OWN_HI_A98 2:1

`define RST_BYTE 8'h00
`define CLK_KHZ 25000
`define STD_KHZ 100
`define FAST_KHZ 400
`define HDR_10BIT 5'h1e
`define GCALL_ADDR 8'h00
`endif

//--- hdl/i2c_iface_pkg.sv
package i2c_iface_pkg;
  typedef enum logic [2:0] {
    st_idle, st_rx, st_tx, st_hold, st_start, st_stop1, st_stop2
  } link_state_type;
  typedef struct packed {
    logic addressed_as_slave_flag;
    logic byte_transfer_finished_flag;
    logic sb;
    logic stop_detected_flag;
    logic af;
    logic arlo;
  } event_flags_type;
endpackage : i2c_iface_pkg

//--- hdl/i2c_iface.sv
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "i2c_iface_map.svh"
module i2c_iface
  import i2c_iface_pkg::*;
#(
  parameter int unsigned CLK_KHZ = `CLK_KHZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic serial_data_pin_i,
  input wire logic serial_clock_pin_i,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe_o,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_o,
  input wire logic gpio_data_i,
  input wire logic gpio_data_oe_i,
  input wire logic gpio_clock_i,
  input wire logic gpio_clock_oe_i
);
  localparam logic [8:0] STD_HALF =
    9'((CLK_KHZ + 2 * `STD_KHZ - 1) / (2 * `STD_KHZ));
  localparam logic [8:0] FAST_HALF =
    9'((CLK_KHZ + 2 * `FAST_KHZ - 1) / (2 * `FAST_KHZ));

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [7:0] ctrl_r, div_r, own_lo_r, own_hi_r, data_r, sh_r;
  event_flags_type flags_r;
  link_state_type st_r;
  logic [3:0] cnt_r;
  logic [8:0] half_r;
  logic gcal_r, tra_r, msl_r, busy_r, sess_r, ten_hdr_r, ten_addr_r;
  logic addr_done_r, addr_hit_r, sr1_seen_r, txload_r, ackd_r;
  logic sda_drv_r, scl_drv_r;
  logic [1:0] sda_sync_r, scl_sync_r;
  logic sda_d_r, scl_d_r;
  logic [7:0] rdata, sr1, sr2;
  logic dec_hit, dec_hdr, dec_tra, dec_gc;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction : hit

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_sync_r <= 2'h3;
      scl_sync_r <= 2'h3;
      sda_d_r <= 1'b1;
      scl_d_r <= 1'b1;
    end else begin
      sda_sync_r <= {sda_sync_r[0], serial_data_pin_i};
      scl_sync_r <= {scl_sync_r[0], serial_clock_pin_i};
      sda_d_r <= sda_sync_r[1];
      scl_d_r <= scl_sync_r[1];
    end
  end

  wire logic sda_s = sda_sync_r[1];
  wire logic scl_s = scl_sync_r[1];
  wire logic scl_rise = scl_s & ~scl_d_r;
  wire logic scl_fall = ~scl_s & scl_d_r;
  wire logic start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire logic stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire logic pe = ctrl_r[`CR_PE];
  wire logic [8:0] half_len =
    (div_r[`DIV_FM] ? FAST_HALF : STD_HALF) + {2'h0, div_r[6:0]}; // [RULE8] [RULE10]

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  wire logic wb_fire = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic wr = wb_fire & wb_we_i & wb_sel_i[0];
  wire logic rd = wb_fire & ~wb_we_i;
  wire logic rd_sr1 = rd & hit(wb_adr_i, `ADR_SR1);
  wire logic rd_sr2 = rd & hit(wb_adr_i, `ADR_SR2);
  wire logic rd_data = rd & hit(wb_adr_i, `ADR_DATA);
  wire logic wr_data = wr & hit(wb_adr_i, `ADR_DATA);
  wire logic start_taken = st_r == st_idle && ctrl_r[`CR_START] && !busy_r;
  wire logic stop_taken = st_r == st_hold && msl_r && ctrl_r[`CR_STOP];

  always_comb begin
    sr1 = 8'h00;
    sr1[`SR1_EVF] = |flags_r;
    sr1[`SR1_TEN] = ten_hdr_r;
    sr1[`SR1_TRA] = tra_r;
    sr1[`SR1_BUSY] = busy_r;
    sr1[`SR1_BTF] = flags_r.byte_transfer_finished_flag;
    sr1[`SR1_ADDRESSED_AS_SLAVE_FLAG] = flags_r.addressed_as_slave_flag;
    sr1[`SR1_MSL] = msl_r;
    sr1[`SR1_SB] = flags_r.sb;
    sr2 = 8'h00;
    sr2[`SR2_AF] = flags_r.af;
    sr2[`SR2_STOP_DETECTED_FLAG] = flags_r.stop_detected_flag;
    sr2[`SR2_ARLO] = flags_r.arlo;
    sr2[`SR2_GCAL] = gcal_r;
    case (wb_adr_i)
      `ADR_CTRL: rdata = ctrl_r;
      `ADR_SR1: rdata = sr1;
      `ADR_SR2: rdata = sr2;
      `ADR_DIV: rdata = div_r;
      `ADR_OWN_LO: rdata = own_lo_r;
      `ADR_OWN_HI: rdata = own_hi_r;
      `ADR_DATA: rdata = data_r;
      default: rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_fire;
      wb_dat_o <= wb_fire && !wb_we_i ? {24'h0, rdata} : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `RST_BYTE;
      div_r <= `RST_BYTE;
      own_lo_r <= `RST_BYTE;
      own_hi_r <= `RST_BYTE;
    end else begin
      if (wr && hit(wb_adr_i, `ADR_CTRL)) ctrl_r <= wb_dat_i[7:0];
      if (wr && hit(wb_adr_i, `ADR_DIV)) div_r <= wb_dat_i[7:0];
      if (wr && hit(wb_adr_i, `ADR_OWN_LO)) own_lo_r <= wb_dat_i[7:0];
      if (wr && hit(wb_adr_i, `ADR_OWN_HI)) own_hi_r <= wb_dat_i[7:0];
      if (start_taken || !pe) ctrl_r[`CR_START] <= 1'b0; // [RULE5]
      if (stop_taken || !pe) ctrl_r[`CR_STOP] <= 1'b0; // [RULE5]
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire logic hdr_ok = sh_r[7:3] == `HDR_10BIT &&
    sh_r[2:1] == own_hi_r[`OWN_HI_A98]; // [RULE14]

  always_comb begin
    dec_hit = 1'b0;
    dec_hdr = 1'b0;
    dec_tra = 1'b0;
    dec_gc = 1'b0;
    if (ctrl_r[`CR_ENGC] && sh_r == `GCALL_ADDR) begin // [RULE6]
      dec_hit = 1'b1;
      dec_gc = 1'b1;
    end else if (!own_hi_r[`OWN_HI_TEN]) begin
      if (sh_r[7:1] == own_lo_r[7:1]) begin // [RULE13]
        dec_hit = 1'b1;
        dec_tra = sh_r[0]; // [RULE18]
      end
    end else if (ten_hdr_r) begin
      dec_hit = sh_r == own_lo_r; // [RULE19]
    end else if (hdr_ok) begin
      if (!sh_r[0]) begin
        dec_hdr = 1'b1; // [RULE15]
      end else if (ten_addr_r) begin
        dec_hit = 1'b1; // [RULE19]
        dec_tra = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // link engine
  // ----------------------------------------------------------------
  wire logic release_ok = !flags_r.addressed_as_slave_flag && !flags_r.byte_transfer_finished_flag && !flags_r.sb &&
    (!tra_r || txload_r);

  always_ff @(posedge clk_i) begin
    if (rst_i || !pe) begin
      st_r <= st_idle; // [RULE1]
      flags_r <= '0;
      data_r <= `RST_BYTE;
      sh_r <= 8'h00;
      cnt_r <= 4'h0;
      half_r <= 9'h000;
      {gcal_r, tra_r, msl_r, busy_r, sess_r} <= 5'h00;
      {ten_hdr_r, ten_addr_r, addr_done_r, addr_hit_r} <= 4'h0;
      {sr1_seen_r, txload_r, ackd_r, sda_drv_r, scl_drv_r} <= 5'h00;
    end else begin
      if (rd_sr1) begin
        flags_r.addressed_as_slave_flag <= 1'b0; // [RULE23]
        sr1_seen_r <= 1'b1;
      end
      if (sr1_seen_r && (rd_data || wr_data)) begin
        flags_r.byte_transfer_finished_flag <= 1'b0; // [RULE24]
        sr1_seen_r <= 1'b0;
        if (wr_data) flags_r.sb <= 1'b0;
      end
      if (rd_sr2) begin
        flags_r.stop_detected_flag <= 1'b0; // [RULE25]
        flags_r.af <= 1'b0;
        flags_r.arlo <= 1'b0;
      end
      if (wr_data) begin
        data_r <= wb_dat_i[7:0];
        if (st_r == st_hold) txload_r <= 1'b1; // [RULE21]
      end
      if (start_det) busy_r <= 1'b1;
      if (stop_det) busy_r <= 1'b0;
      if (msl_r && (st_r == st_rx || st_r == st_tx)) begin
        if (half_r != 9'h000) begin
          if (scl_drv_r || scl_s) half_r <= half_r - 9'h001;
        end else begin
          scl_drv_r <= ~scl_drv_r; // [RULE5] [RULE10]
          half_r <= half_len;
        end
      end
      if (start_det && !msl_r) begin
        st_r <= st_rx; // [RULE3] [RULE13]
        cnt_r <= 4'h0;
        sda_drv_r <= 1'b0;
        scl_drv_r <= 1'b0;
        addr_done_r <= 1'b0;
        ten_hdr_r <= 1'b0;
      end else if (stop_det && !msl_r) begin
        if (sess_r) flags_r.stop_detected_flag <= 1'b1; // [RULE22]
        sess_r <= 1'b0;
        ten_addr_r <= 1'b0;
        st_r <= st_idle;
        sda_drv_r <= 1'b0;
        scl_drv_r <= 1'b0;
      end else begin
        unique case (st_r)
          st_idle: begin
            if (start_taken) begin
              st_r <= st_start; // [RULE1] [RULE5]
              msl_r <= 1'b1;
              sda_drv_r <= 1'b1;
              half_r <= half_len;
            end
          end
          st_start: begin
            if (half_r != 9'h000) begin
              half_r <= half_r - 9'h001;
            end else begin
              scl_drv_r <= 1'b1;
              flags_r.sb <= 1'b1;
              tra_r <= 1'b1;
              addr_done_r <= 1'b0;
              st_r <= st_hold;
            end
          end
          st_rx: begin
            if (scl_rise) begin
              if (cnt_r < 4'h8) sh_r <= {sh_r[6:0], sda_s}; // [RULE2]
              cnt_r <= cnt_r + 4'h1;
            end
            if (scl_fall && cnt_r == 4'h8) begin
              if (!addr_done_r && !msl_r) begin
                if (dec_hit || dec_hdr) begin
                  sda_drv_r <= ctrl_r[`CR_ACK]; // [RULE4] [RULE7] [RULE15]
                  addr_hit_r <= dec_hit;
                  ten_hdr_r <= dec_hdr;
                  if (dec_hit) begin
                    tra_r <= dec_tra; // [RULE18] [RULE19]
                    gcal_r <= dec_gc;
                    ten_addr_r <= ten_addr_r | ten_hdr_r;
                  end
                end else begin
                  st_r <= st_idle; // [RULE16]
                  ten_hdr_r <= 1'b0;
                end
              end else begin
                sda_drv_r <= ctrl_r[`CR_ACK]; // [RULE20] [RULE7]
              end
            end
            if (scl_fall && cnt_r == 4'h9) begin
              sda_drv_r <= 1'b0;
              if (!addr_done_r && !msl_r && !addr_hit_r) begin
                cnt_r <= 4'h0;
              end else begin
                data_r <= sh_r; // [RULE18]
                scl_drv_r <= 1'b1; // [RULE9]
                st_r <= st_hold;
                if (!addr_done_r && !msl_r) begin
                  flags_r.addressed_as_slave_flag <= 1'b1; // [RULE17]
                  addr_done_r <= 1'b1;
                  sess_r <= 1'b1;
                end else begin
                  flags_r.byte_transfer_finished_flag <= 1'b1; // [RULE20]
                end
              end
            end
          end
          st_tx: begin
            if (scl_rise) begin
              if (cnt_r < 4'h8) begin
                sh_r <= {sh_r[6:0], 1'b1}; // [RULE2]
                if (msl_r && !sda_drv_r && !sda_s) begin
                  flags_r.arlo <= 1'b1; // [RULE1]
                  msl_r <= 1'b0;
                  st_r <= st_idle;
                  scl_drv_r <= 1'b0;
                end
              end else begin
                ackd_r <= ~sda_s; // [RULE4]
              end
              cnt_r <= cnt_r + 4'h1;
            end
            if (scl_fall) begin
              if (cnt_r < 4'h8) begin
                sda_drv_r <= ~sh_r[7];
              end else if (cnt_r == 4'h8) begin
                sda_drv_r <= 1'b0;
              end else if (ackd_r) begin
                flags_r.byte_transfer_finished_flag <= 1'b1; // [RULE21]
                scl_drv_r <= 1'b1;
                st_r <= st_hold;
                if (msl_r && !addr_done_r) begin
                  addr_done_r <= 1'b1;
                  tra_r <= ~data_r[0];
                end
              end else begin
                flags_r.af <= 1'b1;
                scl_drv_r <= msl_r;
                st_r <= msl_r ? st_hold : st_idle;
              end
            end
          end
          st_hold: begin
            if (stop_taken) begin
              st_r <= st_stop1; // [RULE5]
              sda_drv_r <= 1'b1;
              half_r <= half_len;
            end else if (release_ok) begin
              scl_drv_r <= msl_r; // [RULE9] [RULE17] [RULE20] [RULE21]
              half_r <= half_len;
              cnt_r <= 4'h0;
              txload_r <= 1'b0;
              if (tra_r) begin
                st_r <= st_tx;
                sh_r <= data_r;
                sda_drv_r <= ~data_r[7];
              end else begin
                st_r <= st_rx;
                sda_drv_r <= 1'b0;
              end
            end
          end
          st_stop1: begin
            if (half_r != 9'h000) begin
              half_r <= half_r - 9'h001;
            end else begin
              scl_drv_r <= 1'b0;
              half_r <= half_len;
              st_r <= st_stop2;
            end
          end
          st_stop2: begin
            if (half_r != 9'h000) begin
              if (scl_s) half_r <= half_r - 9'h001;
            end else begin
              sda_drv_r <= 1'b0;
              msl_r <= 1'b0; // [RULE1]
              st_r <= st_idle;
            end
          end
          default: st_r <= st_idle;
        endcase
      end
    end
  end

  a_boot_slave: assert property ($fell(rst_i) |-> !msl_r) // [RULE1]
    else $error("not slave after reset");
  a_master_exit: assert property ($fell(msl_r) |->
    $past(st_r) == st_stop2 || flags_r.arlo || !pe) // [RULE1]
    else $error("left master without stop or loss");
  a_ack_window: assert property (st_r == st_rx && sda_drv_r |->
    cnt_r == 4'h8 || cnt_r == 4'h9) // [RULE4]
    else $error("receiver drives data outside ack slot");
  a_ack_enable: assert property ($rose(sda_drv_r) && st_r == st_rx |->
    $past(ctrl_r[`CR_ACK])) // [RULE7]
    else $error("ack driven while disabled");
  a_hold_low: assert property (st_r == st_hold |-> scl_drv_r) // [RULE9]
    else $error("clock not held while waiting");
  a_hold_release: assert property ($past(st_r) == st_hold &&
    (st_r == st_rx || st_r == st_tx) |->
    !$past(flags_r.addressed_as_slave_flag) && !$past(flags_r.byte_transfer_finished_flag)) // [RULE17]
    else $error("clock released before service");
  a_stop_sticky: assert property (pe && flags_r.stop_detected_flag && !rd_sr2 |=>
    flags_r.stop_detected_flag || !pe) // [RULE22]
    else $error("stop flag lost without read");
  a_addressed_as_slave_flag_clear: assert property (pe && rd_sr1 && st_r == st_hold |=>
    !flags_r.addressed_as_slave_flag) // [RULE23]
    else $error("address event not cleared");
  a_btf_keep: assert property (pe && flags_r.byte_transfer_finished_flag && !sr1_seen_r &&
    st_r == st_hold |=> flags_r.byte_transfer_finished_flag || !pe) // [RULE24]
    else $error("byte event cleared without status read");

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_data_pin_o <= 1'b0;
      serial_data_pin_oe_o <= 1'b0;
      serial_clock_pin_o <= 1'b0;
      serial_clock_pin_oe_o <= 1'b0;
    end else begin
      serial_data_pin_o <= pe ? 1'b0 : gpio_data_i; // [RULE26] [RULE11]
      serial_data_pin_oe_o <= pe ? sda_drv_r : gpio_data_oe_i;
      serial_clock_pin_o <= pe ? 1'b0 : gpio_clock_i; // [RULE26] [RULE11]
      serial_clock_pin_oe_o <= pe ? scl_drv_r : gpio_clock_oe_i;
    end
  end

  a_open_drain: assert property ($past(pe) |->
    !serial_data_pin_o && !serial_clock_pin_o) // [RULE26]
    else $error("bus line driven high");
  a_port_pass: assert property (!$past(pe) |->
    serial_data_pin_oe_o == $past(gpio_data_oe_i)) // [RULE11]
    else $error("disabled pin not following port");
endmodule : i2c_iface
`default_nettype wire

//--- verification/i2c_remote_master.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------
// remote bus master, open drain, honours holds
// ------------------------------------------------
module i2c_remote_master #(
  parameter int HALF = 30
) (
  input wire logic clk_i,
  input wire logic sda_i,
  input wire logic scl_i,
  output logic sda_low_o,
  output logic scl_low_o
);
  initial begin
    sda_low_o = 1'b0;
    scl_low_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // release clock, wait while a slave holds it
  task automatic rise();
    int n;
    scl_low_o <= 1'b0;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (scl_i !== 1'b1 && n < 4000);
    tick(HALF);
  endtask : rise

  task automatic bit_io(input logic b, output logic r);
    sda_low_o <= !b;
    tick(HALF);
    rise();
    r = sda_i;
    scl_low_o <= 1'b1;
    tick(1);
  endtask : bit_io

  task automatic start();
    sda_low_o <= 1'b0;
    tick(HALF);
    rise();
    sda_low_o <= 1'b1;
    tick(HALF);
    scl_low_o <= 1'b1;
    tick(1);
  endtask : start

  task automatic stop();
    sda_low_o <= 1'b1;
    tick(HALF);
    rise();
    sda_low_o <= 1'b0;
    tick(HALF);
  endtask : stop

  task automatic xfer(input logic [7:0] d, input logic ack_it,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(!ack_it, ack);
    tick(HALF);
  endtask : xfer
endmodule : i2c_remote_master
`default_nettype wire

//--- verification/tb_i2c_iface.sv
`timescale 1ns/100ps
`default_nettype none
`include "i2c_iface_map.svh"
module tb_i2c_iface;
  localparam logic [7:0] f_evf = 8'h01 << `SR1_EVF;
  localparam logic [7:0] f_addressed_as_slave_flag = 8'h01 << `SR1_ADDRESSED_AS_SLAVE_FLAG;
  localparam logic [7:0] f_btf = 8'h01 << `SR1_BTF;
  localparam logic [7:0] f_tra = 8'h01 << `SR1_TRA;
  localparam logic [7:0] f_msl = 8'h01 << `SR1_MSL;
  localparam logic [7:0] f_sb = 8'h01 << `SR1_SB;
  localparam logic [7:0] f_stop = 8'h01 << `SR2_STOP_DETECTED_FLAG;
  localparam logic [7:0] f_gcal = 8'h01 << `SR2_GCAL;
  localparam logic [7:0] c_pe = 8'h01 << `CR_PE;
  localparam logic [7:0] c_ack = 8'h01 << `CR_ACK;
  localparam logic [7:0] c_gc = 8'h01 << `CR_ENGC;
  logic clk_i, rst_i, cyc, stb, we, ack, gd, gdo, gc, gco, en;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic sdo, sdoe, sco, scoe, m_sda_low, m_scl_low;
  wire logic sda, scl;
  int err_count = 0;
  int checks_done = 0;
  // open-drain lines with pull-ups
  assign sda = (sdoe ? sdo : 1'b1) & !m_sda_low;
  assign scl = (scoe ? sco : 1'b1) & !m_scl_low;

  i2c_iface uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .serial_data_pin_i(sda), .serial_clock_pin_i(scl),
    .serial_data_pin_o(sdo), .serial_data_pin_oe_o(sdoe),
    .serial_clock_pin_o(sco), .serial_clock_pin_oe_o(scoe),
    .gpio_data_i(gd), .gpio_data_oe_i(gdo), .gpio_clock_i(gc),
    .gpio_clock_oe_i(gco));
  i2c_remote_master m (.clk_i(clk_i), .sda_i(sda), .scl_i(scl),
    .sda_low_o(m_sda_low), .scl_low_o(m_scl_low));

  // ------------------------------------------------
  // bus cycle and compare tasks
  // ------------------------------------------------
  task automatic end_of_test();
    if (err_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic cmp(input logic [7:0] got, exp, mask, input string s);
    checks_done++;
    if ((got & mask) !== (exp & mask)) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask : cmp

  task automatic wb(input logic w, input logic [7:0] a, d,
                    output logic [7:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat[7:0];
    cmp({7'h00, ack}, 8'h01, 8'h01, "bus answer");
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic chk(input logic [7:0] a, e, mask, input string s);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    cmp(q, e, mask, s);
  endtask : chk

  task automatic hold(input logic e, input string s);
    repeat (3) @(posedge clk_i);
    cmp({7'h00, scoe}, {7'h00, e}, 8'h01, s);
  endtask : hold

  task automatic send(input logic [7:0] d, input logic nack,
                      input string s);
    logic [7:0] q;
    logic a;
    m.xfer(d, 1'b0, q, a);
    cmp({7'h00, a}, {7'h00, nack}, 8'h01, s);
  endtask : send

  task automatic recv(input logic [7:0] e, input logic give);
    logic [7:0] q;
    logic a;
    m.xfer(8'hff, give, q, a);
    cmp(q, e, 8'hff, "tx byte");
  endtask : recv

  task automatic fin();
    logic [7:0] q;
    m.stop();
    wb(1'b0, `ADR_SR2, 8'h00, q);
  endtask : fin

  // ------------------------------------------------
  // clock, watchdog, drive checks
  // ------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  initial begin
    repeat (90000) @(posedge clk_i);
    err_count++;
    end_of_test();
  end

  always @(negedge clk_i) begin
    if (en && sdoe === 1'b1) cmp({7'h00, sdo}, 8'h00, 8'h01, "drive");
  end

  // ------------------------------------------------
  // test sequence
  // ------------------------------------------------
  initial begin : main
    {rst_i, cyc, stb, we, gd, gdo, gc, gco, en} = 9'h100;
    adr = 8'h00;
    sel = 4'hf;
    wdat = 32'h00000000;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) chk(8'(4 * i), 8'h00, 8'hff, "reset");
    wr(8'h1c, 8'hff);
    chk(8'h1c, 8'h00, 8'hff, "unmapped");
    wr(`ADR_OWN_HI, 8'hc0);
    wr(`ADR_DIV, 8'h85);
    chk(`ADR_DIV, 8'h85, 8'hff, "divider");
    wr(`ADR_OWN_LO, 8'ha4);
    wr(`ADR_CTRL, c_pe | c_ack);
    en = 1'b1;
    m.start();
    send(8'ha4, 1'b0, "own addr");
    hold(1'b1, "addr hold");
    chk(`ADR_SR1, f_evf | f_addressed_as_slave_flag, f_evf | f_addressed_as_slave_flag | f_msl, "addressed_as_slave_flag");
    hold(1'b0, "addr release");
    chk(`ADR_SR1, 8'h00, f_addressed_as_slave_flag, "addressed_as_slave_flag clear");
    chk(`ADR_DATA, 8'ha4, 8'hff, "dir bit");
    send(8'h96, 1'b0, "data ack");
    hold(1'b1, "rx hold");
    chk(`ADR_SR1, f_evf | f_btf, f_evf | f_btf, "btf");
    hold(1'b1, "rx hold sr1");
    chk(`ADR_DATA, 8'h96, 8'hff, "rx data");
    hold(1'b0, "rx release");
    m.stop();
    chk(`ADR_SR1, f_evf, f_evf, "stop evf");
    chk(`ADR_SR2, f_stop, f_stop, "stop_detected_flag");
    chk(`ADR_SR2, 8'h00, f_stop, "stop_detected_flag clear");
    m.start();
    send(8'h20, 1'b1, "mismatch");
    send(8'ha4, 1'b1, "ignored");
    chk(`ADR_SR1, 8'h00, f_addressed_as_slave_flag, "no addressed_as_slave_flag");
    fin();
    for (int g = 0; g < 2; g++) begin
      wr(`ADR_CTRL, c_pe | c_ack | (g ? c_gc : 8'h00));
      m.start();
      send(`GCALL_ADDR, !g, "gen call");
      if (g) chk(`ADR_SR2, f_gcal, f_gcal, "gcal flag");
      if (g) chk(`ADR_SR1, f_addressed_as_slave_flag, f_addressed_as_slave_flag, "gcal addressed_as_slave_flag");
      fin();
    end
    wr(`ADR_CTRL, c_pe);
    m.start();
    send(8'ha4, 1'b1, "ack off");
    chk(`ADR_SR1, f_addressed_as_slave_flag, f_addressed_as_slave_flag, "flags no ack");
    fin();
    wr(`ADR_CTRL, c_pe | c_ack);
    m.start();
    send(8'ha5, 1'b0, "read addr");
    chk(`ADR_SR1, f_addressed_as_slave_flag, f_addressed_as_slave_flag, "tx addressed_as_slave_flag");
    hold(1'b1, "tx hold");
    wr(`ADR_DATA, 8'hc3);
    recv(8'hc3, 1'b1);
    chk(`ADR_SR1, f_btf | f_tra, f_btf | f_tra, "tx btf");
    hold(1'b1, "tx hold 2");
    wr(`ADR_DATA, 8'h5a);
    recv(8'h5a, 1'b0);
    fin();
    wr(`ADR_OWN_HI, 8'hc5);
    wr(`ADR_OWN_LO, 8'h3c);
    m.start();
    send(8'hf2, 1'b1, "hdr miss");
    fin();
    m.start();
    send(8'hf4, 1'b0, "hdr ack");
    send(8'h3c, 1'b0, "ten addr");
    chk(`ADR_SR1, f_addressed_as_slave_flag, f_addressed_as_slave_flag | f_tra, "ten rx");
    m.start();
    send(8'hf5, 1'b0, "hdr read");
    chk(`ADR_SR1, f_tra, f_tra, "ten tx");
    wr(`ADR_DATA, 8'h81);
    recv(8'h81, 1'b0);
    fin();
    wr(`ADR_CTRL, c_pe | (8'h01 << `CR_START));
    repeat (15) @(posedge clk_i);
    chk(`ADR_SR1, 8'h00, f_sb, "start early");
    repeat (40) @(posedge clk_i);
    chk(`ADR_SR1, f_msl | f_sb, f_msl | f_sb, "master start");
    hold(1'b1, "start hold");
    wr(`ADR_CTRL, c_pe | (8'h01 << `CR_STOP));
    repeat (150) @(posedge clk_i);
    chk(`ADR_SR1, 8'h00, f_msl, "master stop");
    hold(1'b0, "stop release");
    wr(`ADR_CTRL, 8'h00);
    en = 1'b0;
    gd <= 1'b1;
    gdo <= 1'b1;
    gco <= 1'b1;
    repeat (3) @(posedge clk_i);
    cmp({4'h0, sdo, sdoe, sco, scoe}, 8'h0d, 8'h0f, "port pins");
    end_of_test();
  end
endmodule : tb_i2c_iface
`default_nettype wire
